/* File: logic/idc_core.sv */
// Purpose: fetch/decode/execute of the add, carry-add, and, call, decrement_branch_nonzero_op, word_decrement_op, di, ei subset
// Assumes: program memory on a simple request/ack port; wishbone classic slave for control
// Notes:
// Notes on behaviour
// - carry-add stores dst+src+C, sets C Z S V H, clears D; high nibble 1.
// - add stores dst+src, sets C Z S V H, clears D; high nibble 0.
// - and stores dst&src, sets Z S, clears V, keeps C D H; nibble 5.
// - call: stack pointer minus two, push program counter, jump; D6 direct, D4 indirect.
// - decrement_branch_nonzero_op decrements working register, branches relative -128..+127 when nonzero.
// - word_decrement_op subtracts one from pair, opcodes 80/81, sets Z S V, keeps C.
// - indirect call is two bytes but handled as three.
// - bytes taken as opcode, first operand, second operand.
// - full operands are 8-bit addresses; short ones 4-bit in working group.
// - extended timing adds two clocks to every external bus transaction.
// - blank opcodes have no function; they execute as no-operation.
`include "idc_defines.svh"
module idc_core
(
   input  wire logic        clk,        // 20 MHz system clock
   input  wire logic        reset_n,    // async active-low reset
   input  wire logic [7:0]  wb_adr_i,   // wishbone byte address
   input  wire logic [31:0] wb_dat_i,   // wishbone write data
   output logic      [31:0] wb_dat_o,   // wishbone read data
   input  wire logic [3:0]  wb_sel_i,   // wishbone byte selects
   input  wire logic        wb_we_i,    // wishbone write
   input  wire logic        wb_cyc_i,   // wishbone cycle
   input  wire logic        wb_stb_i,   // wishbone strobe
   output logic             wb_ack_o,   // wishbone ack
   output logic             memReq,     // external memory request
   output logic             memWe,      // external memory write
   output logic      [15:0] memAddr,    // external memory address
   output logic      [7:0]  memWdata,   // external memory write data
   input  wire logic [7:0]  memRdata,   // external memory read data
   input  wire logic        memAck      // external memory ack
);
   import idc_pkg::*;

   // ==========================================================
   // functions
   function automatic logic [7:0] fullAddr(input logic [7:0] a, input logic [3:0] rp);
      fullAddr = (a[7:4] == 4'hE) ? {rp, a[3:0]} : a;
   endfunction

   function automatic logic aluNib(input logic [3:0] n);
      aluNib = (n == `IDC_NIB_ADD) || (n == `IDC_NIB_ADC) || (n == `IDC_NIB_AND);
   endfunction

   function automatic idc_kind_t decodeKind(input logic [7:0] op);
      if (op[3:0] == `IDC_LO_DECREMENT_BRANCH_NONZERO_OP)
         decodeKind = K_DECREMENT_BRANCH_NONZERO_OP;
      else if (op == `IDC_OP_WORD_DECREMENT_OP_RR || op == `IDC_OP_WORD_DECREMENT_OP_IR)
         decodeKind = K_WORD_DECREMENT_OP;
      else if (op == `IDC_OP_CALL_DA || op == `IDC_OP_CALL_IRR)
         decodeKind = K_CALL;
      else if (aluNib(op[7:4]) && op[3:2] != 2'b11 && op[3:1] != 3'h0)
         decodeKind = K_ALU;
      else
         decodeKind = K_NONE;
   endfunction

   // ==========================================================
   // state
   idc_state_t  state_reg;
   idc_kind_t   kind_reg;
   logic [15:0] pc_reg, sp_reg;
   logic [7:0]  op_reg, b1_reg, b2_reg, flags_reg, imask_reg, rp_reg;
   logic [7:0]  ctrl_reg, dst_reg, src_reg, dhi_reg;
   logic [7:0]  rfRd, rfWrAddr, rfWrData, rfRdAddr;
   logic        rfWe, busy, busDone;
   logic [2:0]  waitCnt_reg, rdStep_reg;
   logic [7:0]  dAddr_reg;

   assign busy = (state_reg != ST_IDLE) && (state_reg != ST_HALT);

   idc_regfile uRf
   (
      .clk    (clk),
      .rdAddr (rfRdAddr),
      .rdData (rfRd),
      .wrEn   (rfWe),
      .wrAddr (rfWrAddr),
      .wrData (rfWrData)
   );

   // ==========================================================
   // external bus stretch
   logic [2:0] waitTarget;
   assign waitTarget = ctrl_reg[1] ? 3'(`IDC_BUS_BASE + `IDC_EXT_STRETCH) : 3'(`IDC_BUS_BASE);
   assign busDone    = memReq && memAck && (waitCnt_reg >= waitTarget);

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         waitCnt_reg <= 3'h0;
      end
      else
         waitCnt_reg <= (memReq && !busDone) ? waitCnt_reg + {2'h0, waitCnt_reg != 3'h7} : 3'h0;
   end

   // ==========================================================
   // alu
   logic [8:0]  sum;
   logic [4:0]  hsum;
   logic        cin;
   logic [7:0]  res;
   logic [15:0] wdec;
   assign cin  = (op_reg[7:4] == `IDC_NIB_ADC) ? flags_reg[`IDC_F_C] : 1'b0;
   assign sum  = {1'b0, dst_reg} + {1'b0, src_reg} + {8'h00, cin};
   assign hsum = {1'b0, dst_reg[3:0]} + {1'b0, src_reg[3:0]} + {4'h0, cin};
   assign res  = (op_reg[7:4] == `IDC_NIB_AND) ? (dst_reg & src_reg) : sum[7:0];
   assign wdec = {dhi_reg, dst_reg} - 16'h0001;

   // ==========================================================
   // register file port steering
   always_comb
   begin
      rfRdAddr = dAddr_reg;
      rfWe     = (state_reg == ST_WRITE2) || (state_reg == ST_WRITE && kind_reg inside {K_ALU, K_DECREMENT_BRANCH_NONZERO_OP, K_WORD_DECREMENT_OP});
      rfWrAddr = (state_reg == ST_WRITE2) ? dAddr_reg + 8'h01 : dAddr_reg;
      rfWrData = (state_reg == ST_WRITE2) ? wdec[7:0] :
                 (kind_reg == K_DECREMENT_BRANCH_NONZERO_OP) ? dst_reg - 8'h01 :
                 (kind_reg == K_WORD_DECREMENT_OP) ? wdec[15:8] : res;
   end

   // ==========================================================
   // sequencer
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg  <= ST_IDLE;
         kind_reg   <= K_NONE;
         pc_reg     <= `IDC_RST_PC;
         sp_reg     <= 16'h0000;
         op_reg     <= 8'h00;
         b1_reg     <= 8'h00;
         b2_reg     <= 8'h00;
         flags_reg  <= 8'h00;
         imask_reg  <= 8'h00;
         dst_reg    <= 8'h00;
         src_reg    <= 8'h00;
         dhi_reg    <= 8'h00;
         dAddr_reg  <= 8'h00;
         rdStep_reg <= 3'h0;
         memReq     <= 1'b0;
         memWe      <= 1'b0;
         memAddr    <= 16'h0000;
         memWdata   <= 8'h00;
      end
      else
      begin
         unique case (state_reg)
            ST_IDLE:
            begin
               if (ctrl_reg[0])
               begin
                  state_reg <= ST_FETCH;
                  memReq    <= 1'b1;
                  memWe     <= 1'b0;
                  memAddr   <= pc_reg;
               end
            end
            ST_FETCH, ST_OPND1, ST_OPND2:
            begin
               if (busDone)
               begin
                  pc_reg     <= pc_reg + 16'h0001;
                  memAddr    <= pc_reg + 16'h0001;
                  rdStep_reg <= 3'h0;
                  if (state_reg == ST_FETCH)
                     op_reg <= memRdata;
                  else if (state_reg == ST_OPND1)
                     b1_reg <= memRdata;
                  else
                     b2_reg <= memRdata;
                  // three-byte forms take a second operand, the indirect call included
                  if (state_reg == ST_FETCH && (memRdata == `IDC_OP_DI || memRdata == `IDC_OP_EI))
                  begin
                     kind_reg  <= K_MASK;
                     memReq    <= 1'b0;
                     state_reg <= ST_EXEC;
                  end
                  else if (state_reg == ST_FETCH)
                     state_reg <= ST_OPND1;
                  else if (state_reg == ST_OPND1 && (op_reg == `IDC_OP_CALL_DA || op_reg == `IDC_OP_CALL_IRR ||
                           ((op_reg[3:0] == 4'h4 || op_reg[3:0] == 4'h6) && aluNib(op_reg[7:4]))))
                     state_reg <= ST_OPND2;
                  else
                  begin
                     memReq    <= 1'b0;
                     state_reg <= ST_READ;
                  end
               end
            end
            ST_READ:
            begin
               // fetch operands through the registered read port
               rdStep_reg <= rdStep_reg + 3'h1;
               unique case (rdStep_reg)
                  3'h0:
                  begin
                     kind_reg  <= decodeKind(op_reg);
                     // decrement_branch_nonzero_op names its register in the opcode; short r2 source; else a full operand
                     dAddr_reg <= (op_reg[3:0] == `IDC_LO_DECREMENT_BRANCH_NONZERO_OP) ? {rp_reg[7:4], op_reg[7:4]} :
                                  (op_reg[3:0] == 4'h2) ? {rp_reg[7:4], b1_reg[3:0]} :
                                  fullAddr(b1_reg, rp_reg[7:4]);
                     if (decodeKind(op_reg) == K_NONE)
                        state_reg <= ST_IDLE;
                  end
                  3'h1: ;
                  3'h2:
                  begin
                     if (op_reg == `IDC_OP_WORD_DECREMENT_OP_IR && kind_reg == K_WORD_DECREMENT_OP)
                     begin
                        dAddr_reg  <= rfRd;
                        rdStep_reg <= 3'h1;
                        op_reg     <= `IDC_OP_WORD_DECREMENT_OP_RR;
                     end
                     else if (kind_reg == K_ALU)
                     begin
                        src_reg   <= (op_reg[3:0] == 4'h6) ? b2_reg : rfRd;
                        dAddr_reg <= (op_reg[3:0] == 4'h2) ? {rp_reg[7:4], b1_reg[7:4]} :
                                     (op_reg[3:0] == 4'h6) ? fullAddr(b1_reg, rp_reg[7:4]) :
                                     fullAddr(b2_reg, rp_reg[7:4]);
                     end
                     else
                     begin
                        dhi_reg <= rfRd;
                        dst_reg <= rfRd;
                        if (kind_reg != K_DECREMENT_BRANCH_NONZERO_OP)
                           dAddr_reg <= dAddr_reg + 8'h01;
                     end
                  end
                  3'h3: ;
                  default:
                  begin
                     dst_reg   <= (kind_reg == K_WORD_DECREMENT_OP || kind_reg == K_CALL || kind_reg == K_ALU) ? rfRd : dst_reg;
                     if (kind_reg == K_WORD_DECREMENT_OP || kind_reg == K_CALL)
                        dAddr_reg <= dAddr_reg - 8'h01;
                     state_reg <= ST_EXEC;
                  end
               endcase
            end
            ST_EXEC:
            begin
               unique case (kind_reg)
                  K_MASK:
                  begin
                     imask_reg[`IDC_IMASK_EN] <= (op_reg == `IDC_OP_EI);
                     state_reg <= ST_IDLE;
                  end
                  K_CALL:
                  begin
                     sp_reg    <= sp_reg - 16'h0002;
                     memReq    <= 1'b1;
                     memWe     <= 1'b1;
                     memAddr   <= sp_reg - 16'h0002;
                     memWdata  <= pc_reg[15:8];
                     state_reg <= ST_PUSHHI;
                  end
                  K_ALU:
                  begin
                     flags_reg[`IDC_F_Z] <= (res == 8'h00);
                     flags_reg[`IDC_F_S] <= res[7];
                     if (op_reg[7:4] == `IDC_NIB_AND)
                        flags_reg[`IDC_F_V] <= 1'b0;
                     else
                     begin
                        flags_reg[`IDC_F_C] <= sum[8];
                        flags_reg[`IDC_F_V] <= (dst_reg[7] == src_reg[7]) && (res[7] != dst_reg[7]);
                        flags_reg[`IDC_F_D] <= 1'b0;
                        flags_reg[`IDC_F_H] <= hsum[4];
                     end
                     state_reg <= ST_WRITE;
                  end
                  K_WORD_DECREMENT_OP:
                  begin
                     flags_reg[`IDC_F_Z] <= (wdec == 16'h0000);
                     flags_reg[`IDC_F_S] <= wdec[15];
                     flags_reg[`IDC_F_V] <= (wdec == 16'h7FFF);
                     state_reg <= ST_WRITE;
                  end
                  K_DECREMENT_BRANCH_NONZERO_OP:
                  begin
                     if (dst_reg != 8'h01)
                        pc_reg <= pc_reg + {{8{b1_reg[7]}}, b1_reg};
                     state_reg <= ST_WRITE;
                  end
                  default: state_reg <= ST_IDLE;
               endcase
            end
            ST_PUSHHI, ST_PUSHLO:
            begin
               memReq <= 1'b1;
               if (busDone)
               begin
                  memReq    <= 1'b0;
                  memAddr   <= memAddr + 16'h0001;
                  memWdata  <= pc_reg[7:0];
                  state_reg <= (state_reg == ST_PUSHHI) ? ST_PUSHLO : ST_IDLE;
                  if (state_reg == ST_PUSHLO)
                  begin
                     memWe  <= 1'b0;
                     pc_reg <= (op_reg == `IDC_OP_CALL_IRR) ? {dhi_reg, dst_reg} : {b1_reg, b2_reg};
                  end
               end
            end
            ST_WRITE:  state_reg <= (kind_reg == K_WORD_DECREMENT_OP) ? ST_WRITE2 : ST_IDLE;
            ST_WRITE2: state_reg <= ST_IDLE;
            default:   state_reg <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // wishbone slave
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         ctrl_reg <= `IDC_RST_CTRL;
         rp_reg   <= 8'h00;
      end
      else
      begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o)
         begin
            if (wb_we_i && wb_sel_i[0] && wb_adr_i == `IDC_WB_CTRL)
               ctrl_reg <= wb_dat_i[7:0];
            if (wb_we_i && wb_sel_i[1] && wb_adr_i == `IDC_WB_CTRL)
               rp_reg <= wb_dat_i[15:8];
            unique case (wb_adr_i)
               `IDC_WB_CTRL:   wb_dat_o <= {16'h0000, rp_reg, ctrl_reg};
               `IDC_WB_PC:     wb_dat_o <= {sp_reg, pc_reg};
               `IDC_WB_STATUS: wb_dat_o <= {15'h0000, busy, imask_reg, flags_reg};
               default:        wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

/* File: logic/idc_defines.svh */
`ifndef IDC_DEFINES_SVH
`define IDC_DEFINES_SVH
// register offsets of the core's control file
`define IDC_OFS_P3CFG    8'hF7
`define IDC_OFS_P01CFG   8'hF8
`define IDC_OFS_IPRI     8'hF9
`define IDC_OFS_IMASK    8'hFB
`define IDC_OFS_FLAGS    8'hFC
`define IDC_OFS_SPH      8'hFE
`define IDC_OFS_SPL      8'hFF
// wishbone byte addresses of the core control block
`define IDC_WB_CTRL      8'h00
`define IDC_WB_PC        8'h04
`define IDC_WB_STATUS    8'h08
// opcodes
`define IDC_OP_CALL_DA   8'hD6
`define IDC_OP_CALL_IRR  8'hD4
`define IDC_OP_WORD_DECREMENT_OP_RR   8'h80
`define IDC_OP_WORD_DECREMENT_OP_IR   8'h81
`define IDC_OP_DI        8'h8F
`define IDC_OP_EI        8'h9F
`define IDC_NIB_ADD      4'h0
`define IDC_NIB_ADC      4'h1
`define IDC_NIB_AND      4'h5
`define IDC_LO_DECREMENT_BRANCH_NONZERO_OP      4'hA
// flag bit positions
`define IDC_F_C          7
`define IDC_F_Z          6
`define IDC_F_S          5
`define IDC_F_V          4
`define IDC_F_D          3
`define IDC_F_H          2
`define IDC_IMASK_EN     7
// timing
`define IDC_EXT_STRETCH  2
`define IDC_BUS_BASE     3
// reset values
`define IDC_RST_PC       16'h000C
`define IDC_RST_CTRL     8'h00
`endif

/* File: logic/idc_pkg.sv */
// Purpose: types shared by the decoder core
// Assumes: nothing
// Notes:   states of the fetch/execute sequencer
package idc_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_FETCH, ST_OPND1, ST_OPND2, ST_READ, ST_EXEC,
      ST_PUSHLO, ST_PUSHHI, ST_WRITE, ST_WRITE2, ST_HALT
   } idc_state_t;
   typedef enum logic [2:0] {
      K_NONE, K_ALU, K_CALL, K_DECREMENT_BRANCH_NONZERO_OP, K_WORD_DECREMENT_OP, K_MASK
   } idc_kind_t;
endpackage

/* File: logic/idc_regfile.sv */
// Purpose: 256 x 8 register file with registered read port
// Assumes: one write and one read port
// Notes:   control registers at F7..FF are shadowed by the core
module idc_regfile
(
   input  wire logic       clk,       // system clock
   input  wire logic [7:0] rdAddr,    // read address
   output logic      [7:0] rdData,    // registered read data
   input  wire logic       wrEn,      // write strobe
   input  wire logic [7:0] wrAddr,    // write address
   input  wire logic [7:0] wrData     // write data
);
   logic [7:0] mem [0:255];

   always_ff @(posedge clk)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule

/* File: verification/idc_core_chk.sv */
// Purpose: concurrent checks on the decoder core ports
// Assumes: memory partner keeps memAck up until the core moves on
// Notes:   extTiming mirrors control bit1 from acknowledged writes
module idc_core_chk
(
   input wire logic        clk,       // system clock
   input wire logic        reset_n,   // async reset, active low
   input wire logic [7:0]  wb_adr_i,  // wishbone address
   input wire logic [31:0] wb_dat_i,  // wishbone write data
   input wire logic [31:0] wb_dat_o,  // wishbone read data
   input wire logic [3:0]  wb_sel_i,  // byte selects
   input wire logic        wb_we_i,   // write
   input wire logic        wb_cyc_i,  // cycle
   input wire logic        wb_stb_i,  // strobe
   input wire logic        wb_ack_o,  // ack
   input wire logic        memReq,    // memory request
   input wire logic        memWe,     // memory write
   input wire logic [15:0] memAddr,   // memory address
   input wire logic [7:0]  memWdata,  // memory write data
   input wire logic [7:0]  memRdata,  // memory read data
   input wire logic        memAck     // memory ack
);
   logic       extTiming;
   logic       firstReq;
   logic [2:0] reqCnt;
   logic       xferDone;
   assign xferDone = memReq && memAck && (reqCnt >= (extTiming ? 3'h5 : 3'h3));
   // =========================================
   // helper state
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         extTiming <= 1'b0;
      end
      else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h00 && wb_sel_i[0])
      begin
         extTiming <= wb_dat_i[1];
      end
   end
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         firstReq <= 1'b1;
         reqCnt   <= 3'h0;
      end
      else
      begin
         firstReq <= firstReq && !memReq;
         reqCnt   <= (!memReq || xferDone) ? 3'h0 : reqCnt + {2'h0, reqCnt != 3'h7};
      end
   end
   // =========================================
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_wb_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ack_once; wb_ack_o ##1 !wb_ack_o; endsequence
   property p_ack_next; s_wb_req |=> s_ack_once; endproperty
   a_ack_next: assert property (p_ack_next) else $error("wishbone ack not a single pulse after request");
   property p_no_stray; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
   a_no_stray: assert property (p_no_stray) else $error("ack without request");
   property p_unmapped;
      wb_ack_o && !wb_we_i && !(wb_adr_i inside {8'h00, 8'h04, 8'h08}) |-> wb_dat_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_hold; memReq && !xferDone |=> memReq && $stable(memAddr) && $stable(memWe) && $stable(memWdata); endproperty
   a_hold: assert property (p_hold) else $error("memory request changed before completion");
   property p_base_len; $rose(memReq) |-> memReq [*3]; endproperty
   a_base_len: assert property (p_base_len) else $error("memory cycle shorter than three clocks");
   property p_ext_len; $rose(memReq) && extTiming |-> memReq [*5]; endproperty
   a_ext_len: assert property (p_ext_len) else $error("extended memory cycle shorter than five clocks");
   property p_first_fetch; memReq && firstReq |-> memAddr == 16'h000C && !memWe; endproperty
   a_first_fetch: assert property (p_first_fetch) else $error("first fetch not at reset address");
   property p_advance; xferDone |=> !memReq || memWe != $past(memWe) || memAddr != $past(memAddr); endproperty
   a_advance: assert property (p_advance) else $error("core did not move on after completion");
endmodule

bind idc_core idc_core_chk u_chk
(
   .clk(clk), .reset_n(reset_n), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck)
);

/* File: verification/idc_mem_model.sv */
// Purpose: program and data memory on the core's request/ack port
// Assumes: 256-byte image, addresses alias on the low byte
// Notes:   ack after ackDelay cycles, stays up while the request is held
module idc_mem_model
(
   input  wire logic        clk,       // system clock
   input  wire logic        memReq,    // request
   input  wire logic        memWe,     // write
   input  wire logic [15:0] memAddr,   // address
   input  wire logic [7:0]  memWdata,  // write data
   output logic      [7:0]  memRdata,  // read data
   output logic             memAck,    // ack
   input  wire logic [2:0]  ackDelay   // wait before ack
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  store [0:255];
   logic [15:0] lastAddr;
   logic [2:0]  waitCnt;
   logic [7:0]  idlePat = 8'h5A;
   assign memAck = memReq && memAddr == lastAddr && waitCnt >= ackDelay;
   // a released bus shows a moving pattern, never stale data
   assign memRdata = (memReq && !memWe) ? store[memAddr[7:0]] : idlePat;
   always @(posedge clk)
   begin
      lastAddr <= memAddr;
      idlePat  <= {idlePat[6:0], ~idlePat[7]};
      waitCnt  <= (!memReq || memAddr != lastAddr) ? 3'h0 : (waitCnt == 3'h7 ? waitCnt : waitCnt + 3'h1);
      if (memReq && memAck && memWe)
      begin
         store[memAddr[7:0]] <= memWdata;
      end
   end
endmodule

/* File: verification/testbench.sv */
// Purpose: self-checking bench for the decoder core
// Assumes: memory model image loaded between resets
// Notes:   fetch addresses and register reads are compared against queued notes
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, reset_n, cyc, stb, wwe, wbChk, ack, memReq, memWe, memAck, pWe, h;
   logic        pReq = 1'b0;
   logic [3:0]  sel;
   logic [2:0]  ackDelay;
   logic [7:0]  adr, memWdata, memRdata, a, b, c, m, fin, stack_pointer_low;
   logic [8:0]  s1, r;
   logic [15:0] memAddr, pAddr;
   logic [31:0] wdat, rdat, got, sp0;
   logic [63:0] wbExp;
   logic [15:0] fetchQ [$];
   logic [63:0] wbQ [$];
   int          n_fail = 0;
   int          n_compared = 0;
   int          cycles = 0;
   int          seed = 75;
   idc_core dut
   (
      .clk(clk), .reset_n(reset_n), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_sel_i(sel),
      .wb_we_i(wwe), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .memReq(memReq), .memWe(memWe),
      .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck)
   );
   idc_mem_model mem
   (
      .clk(clk), .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
      .memRdata(memRdata), .memAck(memAck), .ackDelay(ackDelay)
   );
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // =========================================
   // compare tasks and monitor
   task chk_fetch(input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e)
      begin
         n_fail++;
         $display("Error fetch address expected %h seen %h", e, g);
      end
   endtask
   task chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g, input logic [31:0] mk);
      n_compared++;
      if ((g & mk) !== (e & mk))
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e & mk, g & mk);
      end
   endtask
   task test_done;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         n_fail++;
         test_done;
      end
      if (pReq && !pWe && (!memReq || memWe || memAddr != pAddr) && fetchQ.size() > 0)
         chk_fetch(fetchQ.pop_front(), pAddr);
      if (ack === 1'b1 && wbChk && wbQ.size() > 0)
      begin
         wbExp = wbQ.pop_front();
         chk_reg("wishbone read", wbExp[31:0], rdat, wbExp[63:32]);
      end
      pReq  <= memReq;
      pWe   <= memWe;
      pAddr <= memAddr;
   end
   // =========================================
   // drivers
   task wb(input logic [7:0] ad, input logic we, input logic [31:0] d, input logic ck, output logic [31:0] q);
      @(posedge clk);
      cyc   <= 1'b1;
      stb   <= 1'b1;
      adr   <= ad;
      wwe   <= we;
      wdat  <= d;
      wbChk <= ck;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc   <= 1'b0;
      stb   <= 1'b0;
      wwe   <= 1'b0;
      wbChk <= 1'b0;
   endtask
   task expect_rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] mk);
      wbQ.push_back({mk, e});
      wb(ad, 1'b0, 32'h0, 1'b1, got);
   endtask
   task do_reset(input logic [7:0] filler);
      reset_n <= 1'b0;
      for (int i = 0; i < 256; i++) mem.store[i] = filler;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
   endtask
   task load(input logic [7:0] at, input logic [7:0] bq [$]);
      foreach (bq[i]) mem.store[at + i] = bq[i];
   endtask
   task expf(input logic [15:0] from, input logic [15:0] to);
      for (int i = from; i <= to; i++) fetchQ.push_back(16'(i));
   endtask
   task automatic go(input logic [31:0] ctrl);
      int k;
      k = 0;
      ackDelay <= 3'($random(seed));
      wb(8'h00, 1'b1, ctrl, 1'b0, got);
      while (fetchQ.size() > 0) @(posedge clk);
      wb(8'h00, 1'b1, ctrl & 32'hFFFFFFFE, 1'b0, got);
      do
      begin
         wb(8'h08, 1'b0, 32'h0, 1'b0, got);
         k++;
      end
      while (got[16] !== 1'b0 && k < 40);
   endtask
   // =========================================
   // main sequence
   initial
   begin
      {reset_n, cyc, stb, wwe, wbChk, adr, wdat, ackDelay} = '0;
      sel = 4'hF;
      for (int it = 0; it < 4; it++)
      begin
         {a, b, c, m} = $random(seed);
         s1  = {1'b0, a} + {1'b0, b};
         r   = {1'b0, s1[7:0]} + {1'b0, c} + {8'h00, s1[8]};
         h   = ({1'b0, s1[3:0]} + {1'b0, c[3:0]} + {4'h0, s1[8]}) > 5'h0F;
         fin = r[7:0] & m;
         do_reset(8'h8F);
         load(8'h0C, {8'h56, 8'h10, 8'h00, 8'h06, 8'h10, a, 8'h06, 8'h10, b, 8'h16, 8'h10, c, 8'h56, 8'h10, m});
         expf(16'h000C, 16'h001B);
         go(32'h1);
         expect_rd(8'h08, {24'h0, r[8], fin == 8'h00, fin[7], 2'b00, h, 2'b00}, 32'hFC);
      end
      $display("arithmetic test done");
      for (int i = 0; i < 2; i++)
      begin
         do_reset(i == 0 ? 8'h9F : 8'h8F);
         wb(8'h08, 1'b0, 32'h0, 1'b0, sp0);
         expf(16'h000C, 16'h000D);
         go(32'h1);
         expect_rd(8'h08, {16'h0, i == 0, 7'h00, sp0[7:0]}, 32'h80FF);
      end
      wb(8'h0C, 1'b1, 32'hFFFFFFFF, 1'b0, got);
      expect_rd(8'h0C, 32'h0, 32'hFFFFFFFF);
      $display("interrupt mask test done");
      do_reset(8'h8F);
      load(8'h0C, {8'h56, 8'h03, 8'h00, 8'h06, 8'h03, 8'h03, 8'h3A, 8'hFE, 8'h3A, 8'h7F});
      load(8'h95, {8'h3A, 8'h80});
      expf(16'h000C, 16'h0013);
      expf(16'h0012, 16'h0013);
      expf(16'h0012, 16'h0015);
      expf(16'h0095, 16'h0096);
      expf(16'h0017, 16'h0017);
      go(32'h3);
      $display("decrement branch test done");
      do_reset(8'h8F);
      load(8'h0C, {8'h56, 8'h20, 8'h00, 8'h56, 8'h21, 8'h00, 8'h06, 8'h21, 8'h80, 8'h56, 8'h22, 8'h00,
                   8'h06, 8'h22, 8'h20, 8'h80, 8'h20, 8'h81, 8'h22, 8'hD6, 8'h00, 8'h40});
      load(8'h40, {8'hD4, 8'h20});
      wb(8'h04, 1'b0, 32'h0, 1'b0, sp0);
      stack_pointer_low = sp0[23:16];
      expf(16'h000C, 16'h0021);
      expf(16'h0040, 16'h0042);
      expf(16'h007E, 16'h007E);
      go(32'h1);
      expect_rd(8'h08, 32'h0, 32'h70);
      expect_rd(8'h04, {sp0[31:16] - 16'd4, 16'h0}, 32'hFFFF0000);
      chk_reg("pushed return addresses", 32'h00220043, {mem.store[stack_pointer_low - 8'd2], mem.store[stack_pointer_low - 8'd1],
              mem.store[stack_pointer_low - 8'd4], mem.store[stack_pointer_low - 8'd3]}, 32'hFFFFFFFF);
      $display("call test done");
      test_done;
   end
endmodule
